// ### src/sram_port_defines.svh
// offsets, field positions, reset values and sizes of the sram bus port
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// core geometry
`define PORT_ADDR_W     8
`define PORT_LANES      4
`define PORT_LANE_W     8
`define PORT_DATA_W     32
`define PORT_FIFO_DEPTH 8

// register port map
`define REG_ADDR_W      8
`define REG_STATUS      8'h00
`define REG_CTRL        8'h04

// status fields
`define ST_OP_LSB       0
`define ST_CNT_LSB      2
`define ST_MODE_BIT     4
`define ST_FULL_BIT     5
`define ST_DRIVE_BIT    6
`define ST_STALL_BIT    7

// control fields and reset values
`define CTRL_HOLD_BIT   0
`define CTRL_RESET      32'h0000_0000
`define MODE_DEFAULT    1'b1

`endif

// ### src/sram_port_pkg.sv
// types shared by the sram bus port and its write buffer
package sram_port_pkg;
  `include "sram_port_defines.svh"

  // access type of a loaded burst, gray along desel -> read -> write
  typedef enum logic [1:0] {
    OP_DESEL = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b11
  } port_op_t;

  // one buffered write on its way to the array
  typedef struct packed {
    logic [`PORT_ADDR_W-1:0] addr;
    logic [`PORT_LANES-1:0]  lane_en;
    logic [`PORT_DATA_W-1:0] data;
    logic [`PORT_LANES-1:0]  par;
  } write_word_t;
endpackage : sram_port_pkg

// ### src/write_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage needs no reset, only the pointers and the count do
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : write_fifo

// ### src/sram_bus_port.sv
// bus-port control of a pipelined burst static memory
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "sram_port_defines.svh"

// Contract
// - selected only when first and third enables low, second high, at a qualified edge.
// - output enable pin gates data drivers without waiting for a clock.
// - no drive during write data phase, after deselect, or while deselected.
// - qualify pin low acts on edges; high holds the burst, data-phase, output and drain state.
// - holding the clock never deselects; the previous cycle just stretches.
// - data pins are captured into a data register at each acted edge of a write data phase.
// - read data appear one acted edge after their address was taken.
// - parity pins follow ordinary data pins in direction, capture and timing.
// - each lane's parity bit is written only with its own lane select.
// - strap high picks interleaved burst order, low picks linear.
// - floating strap reads as high, so interleaved order is the default; no pull-up here: mode resets high, then takes the synchronized strap.
// - a write starts only with write enable low at a qualified edge.
// - advance high steps the burst counter; low loads a new address.
// - deselect taken at one edge tri-states outputs after the next edge.
// - bursts walk the two low address bits only, four beats, then wrap.
module sram_bus_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W     = `PORT_ADDR_W,
  parameter int FIFO_DEPTH = `PORT_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // synchronous control from the memory controller
  input  wire logic                    chip_sel_first_n,
  input  wire logic                    chip_sel_second,
  input  wire logic                    chip_sel_third_n,
  input  wire logic                    clk_qualify_n,
  input  wire logic                    advance_or_load,
  input  wire logic                    write_en_n,
  input  wire logic [`PORT_LANES-1:0]  lane_write_sel_n,
  input  wire logic [ADDR_W-1:0]       addr,
  // asynchronous output enable and burst-order strap
  input  wire logic                    output_en_n,
  input  wire logic                    burst_order_strap,
  // data pins
  input  wire logic [`PORT_DATA_W-1:0] dq_in,
  output logic [`PORT_DATA_W-1:0]      dq_out,
  output logic                         dq_oe,
  // parity data pins
  input  wire logic [`PORT_LANES-1:0]  parity_data_pins_in,
  output logic [`PORT_LANES-1:0]       parity_data_pins_out,
  output logic                         parity_data_pins_oe,
  // register port
  input  wire logic [`REG_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata,
  // write buffer back-pressure
  output logic                         write_stall
);
  localparam int WORD_W = $bits(write_word_t);

  logic [`PORT_DATA_W+`PORT_LANES-1:0] mem [2**ADDR_W];

  logic                       qual;
  logic                       sel;
  logic                       load;
  logic                       adv;
  port_op_t                   op;
  logic [ADDR_W-1:0]          base;
  logic [1:0]                 cnt;
  port_op_t                   ph;
  logic [ADDR_W-1:0]          ph_addr;
  logic [`PORT_LANES-1:0]     ph_lanes;
  logic                       drive;
  logic                       mode;
  logic                       strap_taken;
  logic                       strap_meta;
  logic                       strap_sync;
  logic                       wr_load;
  write_word_t                hold;
  logic                       hold_valid;
  logic                       buf_ready;
  logic                       drain_valid;
  logic                       drain_ready;
  logic [WORD_W-1:0]          drain_bits;
  write_word_t                drain;
  logic [31:0]                ctrl;
  logic [`PORT_DATA_W+`PORT_LANES-1:0] rd_word;

  // burst address low bits for a given beat
  function automatic logic [1:0] beat_low(input logic il, input logic [1:0] start,
                                          input logic [1:0] n);
    beat_low = il ? (start ^ n) : 2'(start + n);
  endfunction : beat_low

  // edge qualification and select decode
  assign qual = ~clk_qualify_n;
  assign sel  = ~chip_sel_first_n & chip_sel_second & ~chip_sel_third_n;
  assign load = qual & ~advance_or_load;
  assign adv  = qual & advance_or_load;
  assign rd_word = mem[ph_addr];
  assign wr_load = load & sel & ~write_en_n;

  // strap pin passes two flops; no reset, so they already hold its level at release
  always_ff @(posedge clk) begin
    strap_meta <= burst_order_strap;
    strap_sync <= strap_meta;
  end

  // strap caught once after reset release; later changes are ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode        <= `MODE_DEFAULT;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      mode        <= strap_sync;
      strap_taken <= 1'b1;
    end
  end

  // burst context: loaded on a load edge, stepped on an advance edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op   <= OP_DESEL;
      base <= '0;
      cnt  <= 2'h0;
    end else if (load) begin
      if (sel) begin
        op   <= write_en_n ? OP_READ : OP_WRITE;
        base <= addr;
        cnt  <= 2'h0;
      end else begin
        op <= OP_DESEL;
      end
    end else if (adv) begin
      cnt <= cnt + 2'h1;
    end
  end

  // data-phase context; unqualified edges leave it untouched
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph       <= OP_DESEL;
      ph_addr  <= '0;
      ph_lanes <= '0;
    end else if (load) begin
      ph       <= sel ? (write_en_n ? OP_READ : OP_WRITE) : OP_DESEL;
      ph_addr  <= addr;
      ph_lanes <= ~lane_write_sel_n;
    end else if (adv) begin
      // advance ignores the enables and keeps the latched access type
      ph       <= op;
      ph_addr  <= {base[ADDR_W-1:2], beat_low(mode, base[1:0], cnt + 2'h1)};
      ph_lanes <= ~lane_write_sel_n;
    end
  end

  // read output register, one acted edge behind the address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive                <= 1'b0;
      dq_out               <= '0;
      parity_data_pins_out <= '0;
    end else if (qual) begin
      // write data phase and deselect both leave the drivers off; a write loaded
      // right behind a read cuts that read short rather than fight its data
      drive                <= (ph == OP_READ) & ~wr_load;
      dq_out               <= rd_word[`PORT_DATA_W+`PORT_LANES-1:`PORT_LANES];
      parity_data_pins_out <= rd_word[`PORT_LANES-1:0];
    end
  end

  // pin gating is combinational so the enable pin needs no clock
  assign dq_oe               = drive & ~output_en_n;
  assign parity_data_pins_oe = drive & ~output_en_n;

  // data register: pins sampled on a write data edge, then pushed to the buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold       <= '0;
      hold_valid <= 1'b0;
    end else if (qual && ph == OP_WRITE) begin
      hold.addr    <= ph_addr;
      hold.lane_en <= ph_lanes;
      hold.data    <= dq_in;
      hold.par     <= parity_data_pins_in;
      hold_valid   <= 1'b1;
    end else if (buf_ready) begin
      hold_valid <= 1'b0;
    end
  end

  // a full buffer is reported so the controller can pause writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_stall <= 1'b0;
    end else begin
      write_stall <= hold_valid & ~buf_ready;
    end
  end

  // buffer drains only on acted edges and while software allows it
  assign drain_ready = qual & ~ctrl[`CTRL_HOLD_BIT];
  assign drain       = write_word_t'(drain_bits);

  write_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (hold_valid),
    .in_ready  (buf_ready),
    .in_data   (WORD_W'(hold)),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_bits)
  );

  // array write, lane by lane with its parity bit
  always_ff @(posedge clk) begin
    if (drain_valid && drain_ready) begin
      for (int l = 0; l < `PORT_LANES; l++) begin
        if (drain.lane_en[l]) begin
          mem[drain.addr][`PORT_LANES+l*`PORT_LANE_W +: `PORT_LANE_W] <=
            drain.data[l*`PORT_LANE_W +: `PORT_LANE_W];
          mem[drain.addr][l] <= drain.par[l];
        end
      end
    end
  end

  // control register write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `CTRL_RESET;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      ctrl <= {31'h0, reg_wdata[`CTRL_HOLD_BIT]};
    end
  end

  // read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_STATUS: begin
          reg_rdata <= {24'h0, write_stall, drive, ~buf_ready, mode, cnt, op};
        end
        `REG_CTRL: begin
          reg_rdata <= ctrl;
        end
        default: begin
          reg_rdata <= 32'h0;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_sel_decode: assert property (load && !sel |=> ph == OP_DESEL && op == OP_DESEL)
    else $error("deselect not taken");
  a_oe_async: assert property (dq_oe |-> !output_en_n && drive)
    else $error("driving with output enable high");
  a_write_quiet: assert property (qual && ph == OP_WRITE |=> !dq_oe)
    else $error("driving during write data phase");
  a_write_phase: assert property (wr_load |=> !dq_oe && !parity_data_pins_oe)
    else $error("driving while write data is presented");
  a_hold_state: assert property (clk_qualify_n |=> $stable(cnt) && $stable(ph_addr))
    else $error("state moved on a masked edge");
  a_no_deselect: assert property (clk_qualify_n && op != OP_DESEL |=> $stable(op))
    else $error("masked edge changed the access");
  a_data_capture: assert property (qual && ph == OP_WRITE |=> hold.data == $past(dq_in))
    else $error("write data not captured");
  a_read_pipe: assert property (qual && ph == OP_READ && !wr_load |=> drive)
    else $error("read data not driven one edge later");
  a_parity_follow: assert property (parity_data_pins_oe == dq_oe)
    else $error("parity direction differs from data");
  a_lane_pair: assert property (qual && ph == OP_WRITE |=> hold.lane_en == $past(ph_lanes))
    else $error("lane select not paired with data");
  a_write_start: assert property (load && sel && !write_en_n |=> ph == OP_WRITE)
    else $error("write not started");
  a_burst_step: assert property (adv |=> cnt == 2'($past(cnt) + 2'h1))
    else $error("burst counter did not step");
  a_desel_pipe: assert property (load && !sel ##1 qual |=> !drive)
    else $error("outputs still on after deselect");
  a_lin_order: assert property (adv && !mode |=>
      ph_addr[1:0] == 2'($past(base[1:0]) + $past(cnt) + 2'h1))
    else $error("linear burst address wrong");
  a_il_order: assert property (adv && mode |=>
      ph_addr[1:0] == ($past(base[1:0]) ^ 2'($past(cnt) + 2'h1)))
    else $error("interleaved burst address wrong");

  c_read: cover property (load && sel && write_en_n ##1 qual ##0 drive == 1'b0 ##1 drive);
  c_write: cover property (load && sel && !write_en_n ##1 qual ##1 hold_valid);
  c_burst_wrap: cover property (adv && cnt == 2'h3);
  c_stretch: cover property (clk_qualify_n && op == OP_READ [*2]);
  c_buffer_full: cover property (write_stall);
endmodule : sram_bus_port

// ### testbench/sram_ctl_model.sv
// memory controller model that drives the pipelined sram port
`timescale 1ns/1ps
module sram_ctl_model (
  // clock
  input  wire logic   clk,
  // control pins toward the port
  output logic        chip_sel_first_n,
  output logic        chip_sel_second,
  output logic        chip_sel_third_n,
  output logic        advance_or_load,
  output logic        write_en_n,
  output logic [3:0]  lane_write_sel_n,
  output logic [7:0]  addr,
  // value the controller puts on the shared data and parity pins
  output logic [35:0] bus_data
);
  logic [35:0] pend;
  logic        pend_wr;

  // idle, deselected, pins released
  initial begin
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = 3'b100;
    advance_or_load = 1'b0;
    write_en_n = 1'b1;
    lane_write_sel_n = 4'hf;
    addr = 8'h00;
    bus_data = 36'h0;
    pend = 36'h0;
    pend_wr = 1'b0;
  end

  // one controller cycle; write data follows one edge after its address
  task op(input logic [2:0] cs, input logic adv, input logic we, input logic [7:0] a,
          input logic [3:0] bw, input logic [35:0] wd);
    @(posedge clk);
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} <= cs;
    advance_or_load <= adv;
    write_en_n <= we;
    lane_write_sel_n <= bw;
    addr <= a;
    // released pins flip each cycle so a stale copy can never pass for data
    bus_data <= pend_wr ? pend : ~bus_data;
    pend <= wd;
    pend_wr <= ~we;
  endtask : op
endmodule : sram_ctl_model

// ### testbench/sram_bus_port_tb.sv
// self-checking bench of the sram bus port
`timescale 1ns/1ps
module sram_bus_port_tb;
  import sram_port_pkg::*;
  localparam int LIMIT = 3000;
  typedef struct packed {
    logic [2:0]  cs;
    logic [3:0]  bw;
    logic [7:0]  a;
    logic [35:0] d;
  } row_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_qualify_n = 1'b0;
  logic        output_en_n = 1'b0;
  logic        burst_order_strap = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        first_n, second, third_n, adv, we_n, dq_oe, par_oe, write_stall;
  logic [3:0]  bw_n, par_in, par_out;
  logic [7:0]  addr;
  logic [35:0] bus;
  logic [31:0] dq_in, dq_out, reg_rdata, v;
  logic [35:0] shadow [256];
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // cs is {first_n, second, third_n}; only 010 selects
  row_t rows [7] = '{'{3'b010, 4'h0, 8'h10, 36'h5_a1b2c3d4}, '{3'b010, 4'he, 8'h10, 36'ha_00000011},
                     '{3'b010, 4'h5, 8'h10, 36'hf_22334455}, '{3'b110, 4'h0, 8'h10, 36'h0_0},
                     '{3'b000, 4'h0, 8'h10, 36'h0_0}, '{3'b011, 4'h0, 8'h10, 36'h0_0},
                     '{3'b010, 4'h0, 8'hff, 36'h3_c0ffee01}};

  // 25 ns clock
  always #12.5 clk = ~clk;
  // shared pins: the port wins while it drives
  assign dq_in = dq_oe ? dq_out : bus[31:0];
  assign par_in = par_oe ? par_out : bus[35:32];

  sram_ctl_model sram_ctl_model_i (.clk(clk), .chip_sel_first_n(first_n),
    .chip_sel_second(second), .chip_sel_third_n(third_n), .advance_or_load(adv),
    .write_en_n(we_n), .lane_write_sel_n(bw_n), .addr(addr), .bus_data(bus));

  sram_bus_port #(.ADDR_W(8), .FIFO_DEPTH(8)) sram_bus_port_i (.clk(clk), .nrst(nrst),
    .chip_sel_first_n(first_n), .chip_sel_second(second), .chip_sel_third_n(third_n),
    .clk_qualify_n(clk_qualify_n), .advance_or_load(adv), .write_en_n(we_n),
    .lane_write_sel_n(bw_n), .addr(addr), .output_en_n(output_en_n),
    .burst_order_strap(burst_order_strap), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .parity_data_pins_in(par_in), .parity_data_pins_out(par_out),
    .parity_data_pins_oe(par_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .write_stall(write_stall));

  task chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // register access: one strobe cycle, read data stand the cycle after
  task rw(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rw

  task desel(input int n);
    repeat (n) sram_ctl_model_i.op(3'b100, 1'b0, 1'b1, 8'h00, 4'hf, 36'h0);
  endtask : desel

  function logic [1:0] beat(input logic [1:0] s, input logic [1:0] j, input logic il);
    return il ? s ^ j : s + j;
  endfunction : beat

  task rd_mem(input logic [7:0] a, input logic [35:0] e);
    sram_ctl_model_i.op(3'b010, 1'b0, 1'b1, a, 4'hf, 36'h0);
    desel(2);
    #1 chk({par_out, dq_out}, e);
    chk(36'(dq_oe & par_oe), 36'h1);
    desel(1);
    #1 chk(36'(dq_oe | par_oe), 36'h0);
  endtask : rd_mem

  task wr_mem(input logic [2:0] cs, input logic [3:0] bw, input logic [7:0] a,
              input logic [35:0] d);
    sram_ctl_model_i.op(cs, 1'b0, 1'b0, a, bw, d);
    desel(1);
    #1 chk(36'(dq_oe | par_oe), 36'h0);
    desel(6);
    // lane l owns data byte l and parity bit l
    if (cs == 3'b010) for (int l = 0; l < 4; l++) if (!bw[l]) begin
      shadow[a][8*l +: 8] = d[8*l +: 8];
      shadow[a][32+l] = d[32+l];
    end
  endtask : wr_mem

  // four-beat burst; reads start at 1, where the two orders differ
  task burst(input logic wr, input logic [1:0] start, input logic [35:0] base, input logic il);
    for (int n = 0; n < 6; n++) begin
      sram_ctl_model_i.op((n < 4) ? 3'b010 : 3'b100, n > 0 && n < 4,
                          (wr && n < 4) ? 1'b0 : 1'b1, {6'h08, start}, 4'h0, base + 36'(n));
      #1;
      if (!wr && n >= 2) chk({par_out, dq_out}, base + 36'(beat(start, 2'(n - 2), il)));
    end
    desel(6);
  endtask : burst

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 chk({write_stall, dq_oe, par_oe, reg_rdata}, 36'h0);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rw(1'b0, 8'h00, 32'h0, v);
    chk(36'(v[4]), 36'h1);
    foreach (rows[i]) begin
      wr_mem(rows[i].cs, rows[i].bw, rows[i].a, rows[i].d);
      rd_mem(rows[i].a, shadow[rows[i].a]);
    end
    // read then write back to back: the write data phase owns the pins
    sram_ctl_model_i.op(3'b010, 1'b0, 1'b1, 8'h10, 4'hf, 36'h0);
    sram_ctl_model_i.op(3'b010, 1'b0, 1'b0, 8'h30, 4'h0, 36'h7_76543210);
    desel(1);
    #1 chk(36'(dq_oe | par_oe), 36'h0);
    desel(6);
    rd_mem(8'h30, 36'h7_76543210);
    // stretched read: masked edges hold data and drive
    sram_ctl_model_i.op(3'b010, 1'b0, 1'b1, 8'h10, 4'hf, 36'h0);
    desel(1);
    @(posedge clk) clk_qualify_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({par_out, dq_out}, shadow[8'h10]);
    chk(36'(dq_oe), 36'h1);
    @(posedge clk) output_en_n <= 1'b1;
    #1 chk(36'(dq_oe | par_oe), 36'h0);
    @(posedge clk) output_en_n <= 1'b0;
    clk_qualify_n <= 1'b0;
    desel(2);
    burst(1'b1, 2'd0, 36'h9_00000100, 1'b1);
    burst(1'b0, 2'd1, 36'h9_00000100, 1'b1);
    // held drain: fill the buffer until it pushes back, then release it
    rw(1'b1, 8'h04, 32'h1, v);
    for (int n = 0; n < 20 && write_stall !== 1'b1; n++) begin
      sram_ctl_model_i.op(3'b010, 1'b0, 1'b0, 8'h40 + 8'(n), 4'h0, 36'(n));
      #1;
    end
    desel(2);
    chk(36'(write_stall), 36'h1);
    rw(1'b0, 8'h00, 32'h0, v);
    chk(36'(v[5]), 36'h1);
    rw(1'b0, 8'h08, 32'h0, v);
    chk(36'(v), 36'h0);
    rw(1'b1, 8'h04, 32'h0, v);
    desel(16);
    #1 chk(36'(write_stall), 36'h0);
    // strap changes only while the memory is held in reset
    @(posedge clk) nrst <= 1'b0;
    burst_order_strap <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rw(1'b0, 8'h00, 32'h0, v);
    chk(36'(v[4]), 36'h0);
    burst(1'b1, 2'd0, 36'h6_00000200, 1'b0);
    burst(1'b0, 2'd1, 36'h6_00000200, 1'b0);
    end_of_test();
  end
endmodule : sram_bus_port_tb
